// ---- shared/nesr_map.svh ----
// Register map, field positions, command bytes and timing figures of the NAND controller
`ifndef NESR_MAP_SVH
`define NESR_MAP_SVH

// Register byte offsets
`define NESR_OFF_CTRL 8'h00
`define NESR_OFF_ADDR 8'h04
`define NESR_OFF_STAT 8'h08
`define NESR_OFF_ID 8'h0C

// Control register fields
`define NESR_CTRL_OP_LSB 0
`define NESR_CTRL_GO 4
`define NESR_CTRL_WP 8
`define NESR_CTRL_CHIP_LSB 12

// Status register fields
`define NESR_STAT_BUSY 0
`define NESR_STAT_DONE 1
`define NESR_STAT_FAIL 2
`define NESR_STAT_TOUT 3
`define NESR_STAT_REFUSED 4
`define NESR_STAT_SR_LSB 8

// Reset values
`define NESR_CTRL_RST 32'h0000_0000
`define NESR_ADDR_RST 10'h000

// Command bytes
`define NESR_CMD_ERASE1 8'h60
`define NESR_CMD_ERASE2 8'hD0
`define NESR_CMD_ID 8'h90
`define NESR_CMD_ID_ADDR 8'h00
`define NESR_CMD_STATUS 8'h70
`define NESR_CMD_RESET 8'hFF

// Status byte bits and block geometry
`define NESR_SR_PASS_FAIL 0
`define NESR_SR_READY 6
`define NESR_PAGES_PER_BLOCK 64
`define NESR_PAGE_BITS 6

// Timing figures in their own units
`define NESR_CLK_MHZ 20
`define NESR_T_WB_NS 100
`define NESR_T_WHR_NS 60
`define NESR_T_ADL_NS 100
`define NESR_T_GO_BUSY_US 5
`define NESR_T_ERASE_MS 3
`define NESR_T_RST_ERASE_US 500

`endif

// ---- shared/nesr_pkg.sv ----
// Types shared by the NAND controller files
package nesr_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    NESR_S_IDLE = 8'h01,
    NESR_S_CMD = 8'h02,
    NESR_S_ADDR = 8'h04,
    NESR_S_CMD2 = 8'h08,
    NESR_S_WAIT = 8'h10,
    NESR_S_GAP = 8'h20,
    NESR_S_READ = 8'h40,
    NESR_S_DONE = 8'h80
  } nesr_state_e;

  // Operations software can order
  typedef enum logic [1:0] {
    NESR_OP_STATUS = 2'h0,
    NESR_OP_ID = 2'h1,
    NESR_OP_ERASE = 2'h2,
    NESR_OP_RESET = 2'h3
  } nesr_op_e;

  // Flash strobe and data pins driven by the controller
  typedef struct packed {
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io_out;
    logic io_oe_n;
  } nesr_pins_s;

endpackage : nesr_pkg

// ---- design/nesr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module nesr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : nesr_sync

`default_nettype wire

// ---- design/nesr_ctrl.sv ----
// NAND flash controller for block erase, ID read, status read and reset
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "nesr_map.svh"

module nesr_ctrl
  import nesr_pkg::*;
#(
  parameter int CHIPS = 4,
  parameter int ERASE_CYC = `NESR_T_ERASE_MS * 1000 * `NESR_CLK_MHZ,
  parameter int RESET_CYC = `NESR_T_RST_ERASE_US * `NESR_CLK_MHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [CHIPS-1:0] ce_n,
  output nesr_pins_s pins,
  output logic wp_n,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);

  localparam int TW = 17;
  localparam int CW = (CHIPS > 1) ? $clog2(CHIPS) : 1;
  localparam int WB_CYC = (`NESR_T_WB_NS * `NESR_CLK_MHZ + 999) / 1000 + 2;
  localparam int WHR_CYC = (`NESR_T_WHR_NS * `NESR_CLK_MHZ + 999) / 1000;
  localparam int ADL_CYC = (`NESR_T_ADL_NS * `NESR_CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = (WHR_CYC > ADL_CYC) ? WHR_CYC : ADL_CYC;
  localparam int GOB_CYC = `NESR_T_GO_BUSY_US * `NESR_CLK_MHZ;
  localparam logic [TW-1:0] ERASE_LIM = TW'(ERASE_CYC);
  localparam logic [TW-1:0] RESET_LIM = TW'(RESET_CYC);

  // Elaboration checks
  initial begin
    if (CHIPS < 1 || CHIPS > 16) $error("CHIPS must be 1 to 16");
    if (ERASE_CYC < GOB_CYC + 1 || ERASE_CYC >= 2 ** TW) $error("ERASE_CYC out of range");
    if (RESET_CYC < GOB_CYC + 1 || RESET_CYC >= 2 ** TW) $error("RESET_CYC out of range");
  end

  nesr_state_e state_q;
  nesr_op_e op_q;
  logic [2:0] phase_q;
  logic [1:0] cnt_q;
  logic [TW-1:0] timer_q;
  logic seen_busy_q;
  logic autost_q;
  logic [7:0] cmd_q;
  logic [CW-1:0] chip_q;
  logic wp_en_q;
  logic [9:0] block_q;
  logic done_q, fail_q, tout_q, refused_q;
  logic [7:0] sr_q;
  logic [31:0] id_q;
  logic rb_s;
  logic [7:0] io_s;
  logic wr, go, accept, allowed, busy;
  nesr_op_e op_new;
  logic [15:0] row_w;
  logic [7:0] addr_byte;
  logic [TW-1:0] limit;
  logic read_status;
  nesr_pins_s pin_d;

  // Pin inputs come from another timing world
  nesr_sync #(.W(9)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({rb_n, io_in}),
    .q({rb_s, io_s})
  );

  // Bus decode; zero-wait slave
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign go = wr && (paddr == `NESR_OFF_CTRL) && pwdata[`NESR_CTRL_GO];
  assign op_new = nesr_op_e'(pwdata[`NESR_CTRL_OP_LSB +: 2]);
  assign busy = (state_q != NESR_S_IDLE);
  // Only status and reset pass while the flash is busy; erase is also refused while protected
  assign allowed = (op_new == NESR_OP_STATUS) || (op_new == NESR_OP_RESET) ||
                   (rb_s && ((op_new != NESR_OP_ERASE) || wp_en_q));
  assign accept = go && !busy && allowed;
  assign pslverr = psel && penable && (paddr != `NESR_OFF_CTRL) && (paddr != `NESR_OFF_ADDR) &&
                   (paddr != `NESR_OFF_STAT) && (paddr != `NESR_OFF_ID);

  // Block number sits above the page bits of the row address
  assign row_w = {block_q, 6'h00};
  assign addr_byte = (op_q == NESR_OP_ID) ? `NESR_CMD_ID_ADDR :
                     (cnt_q == 2'h0) ? row_w[7:0] : row_w[15:8];
  // Reset bound uses the worst case, reset out of an erase
  assign limit = (op_q == NESR_OP_ERASE) ? ERASE_LIM : RESET_LIM;
  assign read_status = autost_q || (op_q == NESR_OP_STATUS);

  // Software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= NESR_OP_STATUS;
      chip_q <= '0;
      wp_en_q <= 1'b0;
      block_q <= `NESR_ADDR_RST;
    end else begin
      if (accept) begin
        op_q <= op_new;
        chip_q <= pwdata[`NESR_CTRL_CHIP_LSB +: CW];
      end
      if (wr && paddr == `NESR_OFF_CTRL && !busy) begin
        wp_en_q <= pwdata[`NESR_CTRL_WP];
      end
      if (wr && paddr == `NESR_OFF_ADDR && !busy) begin
        block_q <= pwdata[9:0];
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tout_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (wr && paddr == `NESR_OFF_STAT) begin
        if (pwdata[`NESR_STAT_DONE]) done_q <= 1'b0;
        if (pwdata[`NESR_STAT_FAIL]) fail_q <= 1'b0;
        if (pwdata[`NESR_STAT_TOUT]) tout_q <= 1'b0;
        if (pwdata[`NESR_STAT_REFUSED]) refused_q <= 1'b0;
      end
      if (state_q == NESR_S_DONE) done_q <= 1'b1;
      if (state_q == NESR_S_READ && phase_q == 3'h5 && autost_q && io_s[`NESR_SR_PASS_FAIL]) begin
        fail_q <= 1'b1;
      end
      if (state_q == NESR_S_WAIT && timer_q >= limit) tout_q <= 1'b1;
      if (go && !accept) refused_q <= 1'b1;
    end
  end

  // Operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= NESR_S_IDLE;
      phase_q <= 3'h0;
      cnt_q <= 2'h0;
      timer_q <= '0;
      seen_busy_q <= 1'b0;
      autost_q <= 1'b0;
      cmd_q <= 8'h00;
    end else begin
      unique case (state_q)
        NESR_S_IDLE: begin
          phase_q <= 3'h0;
          cnt_q <= 2'h0;
          timer_q <= '0;
          autost_q <= 1'b0;
          if (accept) begin
            state_q <= NESR_S_CMD;
            unique case (op_new)
              NESR_OP_STATUS: cmd_q <= `NESR_CMD_STATUS;
              NESR_OP_ID: cmd_q <= `NESR_CMD_ID;
              NESR_OP_ERASE: cmd_q <= `NESR_CMD_ERASE1;
              NESR_OP_RESET: cmd_q <= `NESR_CMD_RESET;
            endcase
          end
        end
        NESR_S_CMD: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == 3'h3) begin
            phase_q <= 3'h0;
            cnt_q <= 2'h0;
            timer_q <= '0;
            seen_busy_q <= 1'b0;
            if (read_status) state_q <= NESR_S_GAP;
            else if (op_q == NESR_OP_RESET) state_q <= NESR_S_WAIT;
            else state_q <= NESR_S_ADDR;
          end
        end
        NESR_S_ADDR: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == 3'h3) begin
            phase_q <= 3'h0;
            cnt_q <= cnt_q + 2'h1;
            timer_q <= '0;
            if (op_q == NESR_OP_ID) begin
              state_q <= NESR_S_GAP;
            end else if (cnt_q == 2'h1) begin
              cmd_q <= `NESR_CMD_ERASE2;
              state_q <= NESR_S_CMD2;
            end
          end
        end
        NESR_S_CMD2: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == 3'h3) begin
            phase_q <= 3'h0;
            timer_q <= '0;
            seen_busy_q <= 1'b0;
            state_q <= NESR_S_WAIT;
          end
        end
        NESR_S_WAIT: begin
          timer_q <= timer_q + TW'(1);
          if (timer_q >= limit) begin
            state_q <= NESR_S_DONE;
          end else if (timer_q >= TW'(WB_CYC)) begin
            if (!rb_s) seen_busy_q <= 1'b1;
            // A ready flash may take a while to drop the busy line
            if (rb_s && (seen_busy_q || timer_q >= TW'(GOB_CYC))) begin
              if (op_q == NESR_OP_ERASE) begin
                autost_q <= 1'b1;
                cmd_q <= `NESR_CMD_STATUS;
                phase_q <= 3'h0;
                state_q <= NESR_S_CMD;
              end else begin
                state_q <= NESR_S_DONE;
              end
            end
          end
        end
        NESR_S_GAP: begin
          timer_q <= timer_q + TW'(1);
          if (timer_q >= TW'(GAP_CYC - 1)) begin
            phase_q <= 3'h0;
            cnt_q <= 2'h0;
            state_q <= NESR_S_READ;
          end
        end
        NESR_S_READ: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == 3'h7) begin
            cnt_q <= cnt_q + 2'h1;
            if (read_status || cnt_q == 2'h3) state_q <= NESR_S_DONE;
          end
        end
        NESR_S_DONE: begin
          state_q <= NESR_S_IDLE;
        end
        default: begin
          state_q <= NESR_S_IDLE;
        end
      endcase
    end
  end

  // Captured read data; status lands in its own byte, ID bytes in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 8'h00;
      id_q <= 32'h0000_0000;
    end else if (state_q == NESR_S_READ && phase_q == 3'h5) begin
      if (read_status) sr_q <= io_s;
      else id_q[8 * cnt_q +: 8] <= io_s;
    end
  end

  // Pin levels; each command or address byte holds four cycles, strobe rises midway
  always_comb begin
    pin_d = '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_out: 8'h00, io_oe_n: 1'b1};
    unique case (state_q)
      NESR_S_CMD, NESR_S_CMD2: begin
        pin_d.cle = 1'b1;
        pin_d.io_out = cmd_q;
        pin_d.io_oe_n = 1'b0;
        pin_d.we_n = (phase_q >= 3'h2);
      end
      NESR_S_ADDR: begin
        pin_d.ale = 1'b1;
        pin_d.io_out = addr_byte;
        pin_d.io_oe_n = 1'b0;
        pin_d.we_n = (phase_q >= 3'h2);
      end
      NESR_S_READ: begin
        pin_d.re_n = (phase_q >= 3'h6);
      end
      default: begin
      end
    endcase
  end

  // Registered pins; only the addressed chip is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_out: 8'h00, io_oe_n: 1'b1};
      ce_n <= '1;
      wp_n <= 1'b0;
    end else begin
      pins <= pin_d;
      wp_n <= wp_en_q;
      for (int i = 0; i < CHIPS; i++) begin
        ce_n[i] <= !(busy && (state_q != NESR_S_DONE) && (chip_q == CW'(i)));
      end
    end
  end

  // Read data is registered in the setup cycle; no program path, so page count stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `NESR_OFF_CTRL: begin
          prdata[`NESR_CTRL_OP_LSB +: 2] <= op_q;
          prdata[`NESR_CTRL_WP] <= wp_en_q;
          prdata[`NESR_CTRL_CHIP_LSB +: CW] <= chip_q;
        end
        `NESR_OFF_ADDR: prdata[9:0] <= block_q;
        `NESR_OFF_STAT: begin
          prdata[`NESR_STAT_BUSY] <= busy;
          prdata[`NESR_STAT_DONE] <= done_q;
          prdata[`NESR_STAT_FAIL] <= fail_q;
          prdata[`NESR_STAT_TOUT] <= tout_q;
          prdata[`NESR_STAT_REFUSED] <= refused_q;
          prdata[`NESR_STAT_SR_LSB +: 8] <= sr_q;
        end
        `NESR_OFF_ID: prdata <= id_q;
        default: begin
        end
      endcase
    end
  end

endmodule : nesr_ctrl

`default_nettype wire

// ---- testbench/nesr_ctrl_monitor.sv ----
// Port checker for the NAND controller
`timescale 1ns/1ns
`default_nettype none
module nesr_ctrl_monitor
  import nesr_pkg::*;
#(
  parameter int CHIPS = 4
) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash side
  input wire logic [CHIPS-1:0] ce_n,
  input wire nesr_pins_s pins,
  input wire logic wp_n,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  logic acc;
  logic mapped;
  // Access phase and decoded offsets
  assign acc = psel && penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A command byte latched by the write strobe rise
  sequence s_cmd(b);
    $rose(pins.we_n) && pins.cle && pins.io_out == b;
  endsequence
  property p_zero_wait; acc |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready low in access");
  property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; acc && mapped |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_latch;
    $rose(pins.we_n) |-> (pins.cle ^ pins.ale) && !pins.io_oe_n && $stable(pins.io_out)
      && !(&ce_n);
  endproperty
  a_latch: assert property (p_latch) else $error("bad latch cycle");
  property p_we_width; $fell(pins.we_n) |-> ##1 !pins.we_n ##1 pins.we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width");
  property p_read_idle; !pins.re_n |-> pins.io_oe_n && !pins.cle && !pins.ale && pins.we_n;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("bus driven during read");
  property p_one_chip; $onehot0(~ce_n); endproperty
  a_one_chip: assert property (p_one_chip) else $error("two chips selected");
  property p_id_addr; s_cmd(8'h90) |-> ##4 ($rose(pins.we_n) && pins.ale && pins.io_out == 8'h00);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address byte missing");
  property p_erase_seq;
    s_cmd(8'h60) |-> ##4 ($rose(pins.we_n) && pins.ale && pins.io_out[5:0] == 6'h00)
      ##4 ($rose(pins.we_n) && pins.ale) ##4 s_cmd(8'hD0);
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("erase sequence broken");
  property p_erase_wp; s_cmd(8'hD0) |-> wp_n; endproperty
  a_erase_wp: assert property (p_erase_wp) else $error("erase while protected");
  // Main scenarios reached
  c_erase: cover property (s_cmd(8'h60));
  c_id: cover property (s_cmd(8'h90));
  c_unmapped: cover property (acc && !mapped);
endmodule : nesr_ctrl_monitor
bind nesr_ctrl nesr_ctrl_monitor #(.CHIPS(CHIPS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ce_n(ce_n), .pins(pins), .wp_n(wp_n), .io_in(io_in), .rb_n(rb_n));
`default_nettype wire

// ---- testbench/nesr_flash_model.sv ----
// Behavioural flash device on the controller's far side
`timescale 1ns/1ns
`default_nettype none
module nesr_flash_model #(
  parameter logic [31:0] ID_CODES = 32'h4433_2211 // Arbitrary code bytes
) (
  // Strobes and data wire
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] bus,
  // Device outputs
  output logic [7:0] io,
  output logic rb_n,
  // Scenario knobs
  input wire logic fail_next,
  input wire logic [31:0] erase_ns
);
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] row_lo = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [9:0] erased_blk = 10'h000;
  logic [1:0] mode = 2'h0;
  logic [1:0] id_idx = 2'h0;
  logic busy = 1'b0;
  logic in_rst = 1'b0;
  logic fail = 1'b0;
  logic n_addr = 1'b0;
  logic [7:0] drv;
  int n_erase = 0;
  int tok = 0;
  // No cache program or cache read here, so their busy bounds never arise
  // Pull-up lifts the busy pin once released
  assign rb_n = busy ? 1'b0 : 1'b1;
  // Live status, so polling sees it change without new strobes
  assign drv = mode == 2'h1 ? {wp_n, ~busy, ~busy, 4'h0, fail} : ID_CODES[id_idx*8 +: 8];
  // Released wire shows the inverse of the last byte
  assign io = (!ce_n && !re_n) ? drv : ~last_q;
  always @(posedge re_n) if (!ce_n) begin
    last_q = drv;
    if (mode == 2'h2) id_idx = id_idx + 2'h1;
  end
  // Later completion is dropped once a reset has bumped the token
  task automatic finish_op(input int t, input logic er);
    if (er) #(erase_ns);
    else #2000;
    // Off the clock edge, so the synchroniser never races the release
    #10;
    if (tok == t) begin
      busy = 1'b0;
      in_rst = 1'b0;
      fail = er ? fail_next : 1'b0;
      if (er) n_erase++;
    end
  endtask : finish_op
  // Commands and addresses latch on the write strobe rise
  always @(posedge we_n) if (!ce_n) begin
    if (cle && (!busy || bus == 8'h70 || bus == 8'hFF)) begin
      if (bus == 8'h70) mode = 2'h1;
      else mode = 2'h0;
      if (bus == 8'hFF && !in_rst) begin
        tok++;
        busy = 1'b1;
        in_rst = 1'b1;
        fork finish_op(tok, 1'b0); join_none
      end
      if (bus == 8'hD0 && last_cmd == 8'h60 && wp_n) begin
        tok++;
        busy = 1'b1;
        fork finish_op(tok, 1'b1); join_none
      end
      last_cmd = bus;
      n_addr = 1'b0;
    end else if (ale && !busy) begin
      if (last_cmd == 8'h90 && bus == 8'h00) begin
        mode = 2'h2;
        id_idx = 2'h0;
      end
      if (n_addr) erased_blk = {bus, row_lo[7:6]};
      else row_lo = bus;
      n_addr = ~n_addr;
    end
  end
endmodule : nesr_flash_model
`default_nettype wire

// ---- testbench/nesr_ctrl_test.sv ----
// Self-checking bench for the NAND controller
`timescale 1ns/1ns
`default_nettype none
module nesr_ctrl_test;
  import nesr_pkg::*;
  localparam logic [31:0] IDC = 32'h4433_2211; // Arbitrary code bytes
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fail_next = 1'b0;
  logic [31:0] erase_ns = 32'd8000;
  logic [31:0] prdata, rv, st;
  logic pready, pslverr, wp_n, rb_n, err;
  logic [3:0] ce_n;
  logic [7:0] bus, f_io;
  nesr_pins_s pins;
  int n_mismatch = 0;
  int cmp_count = 0;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  // Data wire: controller wins while its enable is low
  assign bus = !pins.io_oe_n ? pins.io_out : f_io;
  nesr_ctrl #(.CHIPS(4), .ERASE_CYC(300), .RESET_CYC(200)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .pins(pins), .wp_n(wp_n), .io_in(bus), .rb_n(rb_n));
  nesr_flash_model #(.ID_CODES(IDC)) flash (.ce_n(ce_n[0]), .cle(pins.cle), .ale(pins.ale),
    .we_n(pins.we_n), .re_n(pins.re_n), .wp_n(wp_n), .bus(bus), .io(f_io), .rb_n(rb_n),
    .fail_next(fail_next), .erase_ns(erase_ns));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] exp_sr(input logic wp, input logic f);
    return {wp, 2'b11, 4'h0, f};
  endfunction : exp_sr
  // One transfer; an edge passes first so strobes never toggle twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Protect bit settles before the start pulse
  task automatic go(input logic [1:0] op, input logic wp);
    apb(1'b1, 8'h00, {23'h0, wp, 8'h00});
    apb(1'b1, 8'h00, {23'h0, wp, 3'h0, 1'b1, 2'h0, op});
  endtask : go
  task automatic wait_done();
    int k;
    k = 0;
    rv = 32'h0;
    while (rv[1] !== 1'b1 && k < 400) begin
      apb(1'b0, 8'h08, 32'h0);
      k++;
    end
    st = rv;
    check("done", st[1], 1'b1);
    apb(1'b1, 8'h08, 32'h1F);
  endtask : wait_done
  task automatic run(input logic [1:0] op, input logic wp);
    go(op, wp);
    apb(1'b0, 8'h08, 32'h0);
    check("busy", rv[0], 1'b1);
    wait_done();
  endtask : run
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    logic [9:0] blk;
    int n0;
    void'($urandom(85493));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rv, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check("addr reset", rv, 32'h0);
    apb(1'b0, 8'h10 + 8'(4 * ($urandom % 60)), 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rv, 32'h0);
    run(2'h0, 1'b1);
    check("status", st[15:8], exp_sr(1'b1, 1'b0));
    run(2'h1, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    check("id", rv, IDC);
    // Edge block first, then random ones, some failing
    for (int i = 0; i < 4; i++) begin
      blk = (i == 0) ? 10'h3FF : 10'($urandom);
      fail_next <= 1'($urandom);
      apb(1'b1, 8'h04, {22'h0, blk});
      run(2'h2, 1'b1);
      check("block", flash.erased_blk, blk);
      check("fail", st[2], fail_next);
      check("erase sr", st[15:8], exp_sr(1'b1, fail_next));
    end
    n0 = flash.n_erase;
    go(2'h2, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    check("protect refused", rv[4], 1'b1);
    apb(1'b1, 8'h08, 32'h1F);
    go(2'h2, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0110);
    apb(1'b0, 8'h08, 32'h0);
    check("busy refused", rv[4], 1'b1);
    wait_done();
    check("erase count", flash.n_erase, n0 + 1);
    erase_ns <= 32'd20000;
    go(2'h2, 1'b1);
    wait_done();
    check("timeout", st[3], 1'b1);
    run(2'h3, 1'b1);
    check("reset in time", st[3], 1'b0);
    run(2'h0, 1'b1);
    check("after reset", st[15:8], 8'hE0);
    run(2'h3, 1'b0);
    run(2'h0, 1'b0);
    check("protected sr", st[15:8], exp_sr(1'b0, 1'b0));
    // Status on chip 1: flash on chip 0 stays deselected, wire shows inverse of its last byte
    apb(1'b1, 8'h00, 32'h0000_1010);
    wait_done();
    check("other chip", st[15:8], {~exp_sr(1'b0, 1'b0)});
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl chip", rv, 32'h0000_1000);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : nesr_ctrl_test
`default_nettype wire
